// ### core/ash_pkg.sv
/*
 constants and carrier types for the converter read host.
 assumes a 200 MHz core clock; the serial clock is divided from it.
*/
// How it works
// - mode 0 reads each result as one 16-clock gated burst.
// - data is captured on falling serial clock edges only.
// - mode 1 reads each 16-bit word in a frame of its own.
// - an 8-clock mode 1 frame puts the converter into power-down.
// - mode 1 select is active low, asserted once per word.
// - in mode 1 one strobe both selects the converter and starts capture.
// - mode 1 clock idles high, first edge falling, sampled there.
// - the frame strobe leads the first clock by two clock halves.
// - frame starts come from a fixed-interval timer or a start request.
// - the interval is whole clock periods, starts on one phase.
// - mode 0 burst starts a fixed wait after conversion start.
// - after power-down the first mode 1 frame is a dummy, then wake time is spent.
`default_nettype none

package ash_pkg;
	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned CONV_WAIT_NS   = 3300;
	localparam int unsigned CONV_WAIT_CYC  =
		(CONV_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WAKE_NS        = 4330;
	localparam int unsigned WAKE_CYC       =
		(WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CONVERSION_START_N_LOW_CYC = 4;
	localparam int unsigned SCLK_HALF_CYC  = 10;
	localparam int unsigned SYNC_STAGES    = 2;
	localparam int unsigned WORD_BITS      = 16;
	localparam int unsigned PD_BITS        = 8;
	localparam int unsigned RESULT_BITS    = 12;
	localparam int unsigned BUF_DEPTH      = 2;
	localparam int unsigned INTERVAL_W     = 16;

	typedef enum logic {ASH_MODE0, ASH_MODE1} ash_mode_t;

	typedef struct packed {
		logic conversionStartN;
		logic csN;
		logic sclk;
	} ash_pins_t;

	typedef struct packed {
		logic                   mode1;
		logic [RESULT_BITS-1:0] value;
	} ash_sample_t;
endpackage

`default_nettype wire

// ### core/ash_host.sv
/*
 host controller that starts conversions, drives select and a
 divided serial clock, captures the word and buffers the samples.
 assumes the converter pins are wired directly; serial_out is async.
*/
`timescale 1ns/100ps
`default_nettype none

module ash_host #(
	parameter int unsigned HALF_CYC = ash_pkg::SCLK_HALF_CYC,
	parameter int unsigned DEPTH    = ash_pkg::BUF_DEPTH
) (
	input  wire logic                          core_clk,
	input  wire logic                          resetn,
	input  wire ash_pkg::ash_mode_t            modeSel,
	input  wire logic                          runEn,
	input  wire logic [ash_pkg::INTERVAL_W-1:0] intervalSclk,
	input  wire logic                          startReq,
	input  wire logic                          powerDownReq,
	input  wire logic                          serial_out,
	input  wire logic                          sampleReady,
	output var  ash_pkg::ash_pins_t            pins,
	output var  ash_pkg::ash_sample_t          sample,
	output logic                               sampleValid,
	output logic                               busy,
	output logic                               asleep
);
	import ash_pkg::*;

	localparam int unsigned HW = $clog2(HALF_CYC + 1);
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam int unsigned WW = $clog2(WAKE_CYC + CONV_WAIT_CYC + 1);

	// the last capture must land inside one clock half
	if (HALF_CYC <= SYNC_STAGES + 1)
	begin : g_badHalf
		$error("clock half too short for the input synchroniser");
	end
	if (DEPTH < 2)
	begin : g_badDepth
		$error("buffer needs at least two entries");
	end

	typedef enum logic [2:0] {
		IDLE, CONV, ARM, SHIFT, DRAIN, GAP, WAKE
	} ash_state_t;

	ash_state_t              state_q;
	ash_mode_t               mode_q;
	logic [HW-1:0]           halfCnt_q;
	logic                    phase_q;
	logic [INTERVAL_W-1:0]   perCnt_q;
	logic                    pend_q;
	logic                    pdPend_q;
	logic                    pdFrame_q;
	logic                    dummy_q;
	logic [WW-1:0]           waitCnt_q;
	logic [4:0]              fallsLeft_q;
	logic [SYNC_STAGES-1:0]  capPipe_q;
	logic                    sdMeta_q;
	logic                    sdSync_q;
	logic [WORD_BITS-1:0]    shift_q;
	ash_sample_t             mem_q [DEPTH];
	logic [CW-1:0]           cnt_q;

	logic halfTick;
	logic periodTick;
	logic fallNow;
	logic push;
	logic pop;
	logic startNow;

	assign halfTick   = halfCnt_q == HW'(HALF_CYC - 1);
	assign periodTick = halfTick && phase_q;
	assign fallNow    = state_q == SHIFT && halfTick && pins.sclk;
	assign push       = state_q == DRAIN && capPipe_q == '0
		&& !pdFrame_q && !dummy_q;
	assign pop        = sampleValid && sampleReady;
	// one frame in flight at a time, so a free slot now is free at the end
	assign startNow   = state_q == IDLE && periodTick && pend_q
		&& cnt_q != CW'(DEPTH);

	////////////////////////////////////////////////////////////////////
	// free-running divider: every frame starts on the same clock phase

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			halfCnt_q <= '0;
			phase_q   <= 1'b0;
		end
		else if (halfTick)
		begin
			halfCnt_q <= '0;
			phase_q   <= !phase_q;
		end
		else
			halfCnt_q <= halfCnt_q + HW'(1);
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			perCnt_q <= '0;
			pend_q   <= 1'b0;
		end
		else
		begin
			if (periodTick)
				perCnt_q <= (perCnt_q + 1'b1 >= intervalSclk) ?
					'0 : perCnt_q + 1'b1;
			// a trigger landing with the start is kept, not lost
			if ((periodTick && runEn && perCnt_q == '0) || startReq)
				pend_q <= 1'b1;
			else if (startNow)
				pend_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// frame sequencer

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q     <= IDLE;
			mode_q      <= ASH_MODE0;
			pins        <= '{conversionStartN: 1'b1, csN: 1'b1, sclk: 1'b0};
			waitCnt_q   <= '0;
			fallsLeft_q <= '0;
			pdFrame_q   <= 1'b0;
			dummy_q     <= 1'b0;
			asleep      <= 1'b0;
			pdPend_q    <= 1'b0;
		end
		else
		begin
			if (powerDownReq)
				pdPend_q <= 1'b1;
			case (state_q)
				IDLE:
				begin
					pins.sclk <= modeSel == ASH_MODE1;
					pins.csN  <= 1'b1;
					if (startNow)
					begin
						mode_q <= modeSel;
						if (modeSel == ASH_MODE0)
						begin
							pins.conversionStartN <= 1'b0;
							waitCnt_q <= WW'(CONV_WAIT_CYC - 1);
							state_q   <= CONV;
						end
						else
						begin
							pins.csN <= 1'b0;
							pdFrame_q <= pdPend_q && !asleep;
							// a request landing with the start is kept
							pdPend_q  <= powerDownReq;
							dummy_q   <= asleep;
							state_q   <= ARM;
						end
					end
				end
				CONV:
				begin
					waitCnt_q <= waitCnt_q - WW'(1);
					if (waitCnt_q ==
						WW'(CONV_WAIT_CYC - CONVERSION_START_N_LOW_CYC))
						pins.conversionStartN <= 1'b1;
					if (waitCnt_q == '0)
						state_q <= ARM;
				end
				ARM:
					if (halfTick)
					begin
						fallsLeft_q <= pdFrame_q ? 5'(PD_BITS)
							: 5'(WORD_BITS);
						state_q <= SHIFT;
					end
				SHIFT:
					if (halfTick)
					begin
						pins.sclk <= !pins.sclk;
						if (pins.sclk)
						begin
							fallsLeft_q <= fallsLeft_q - 5'd1;
							// mode 0 parks low after the last fall
							if (fallsLeft_q == 5'd1 && mode_q == ASH_MODE0)
								state_q <= DRAIN;
						end
						else if (fallsLeft_q == '0)
							state_q <= DRAIN;
					end
				DRAIN:
					if (capPipe_q == '0)
					begin
						pins.csN <= 1'b1;
						if (pdFrame_q)
							asleep <= 1'b1;
						state_q <= GAP;
					end
				GAP:
					if (halfTick)
					begin
						pdFrame_q <= 1'b0;
						dummy_q   <= 1'b0;
						if (dummy_q)
						begin
							asleep    <= 1'b0;
							waitCnt_q <= WW'(WAKE_CYC - 1);
							state_q   <= WAKE;
						end
						else
							state_q <= IDLE;
					end
				WAKE:
				begin
					waitCnt_q <= waitCnt_q - WW'(1);
					if (waitCnt_q == '0)
						state_q <= IDLE;
				end
				default:
					state_q <= IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			busy <= 1'b0;
		else
			busy <= state_q != IDLE || startNow;
	end

	////////////////////////////////////////////////////////////////////
	// capture: the synchronised data lags the pin by two cycles

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sdMeta_q  <= 1'b0;
			sdSync_q  <= 1'b0;
			capPipe_q <= '0;
			shift_q   <= '0;
		end
		else
		begin
			sdMeta_q  <= serial_out;
			sdSync_q  <= sdMeta_q;
			capPipe_q <= {capPipe_q[SYNC_STAGES-2:0], fallNow};
			if (capPipe_q[SYNC_STAGES-1])
				shift_q <= {shift_q[WORD_BITS-2:0], sdSync_q};
		end
	end

	////////////////////////////////////////////////////////////////////
	// output buffer; head entry drives the sample port directly

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_q       <= '0;
			sampleValid <= 1'b0;
		end
		else
		begin
			cnt_q       <= cnt_q + CW'(push) - CW'(pop);
			sampleValid <= (cnt_q + CW'(push) - CW'(pop)) != '0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
		else
			for (int i = 0; i < DEPTH; i++)
				if (pop)
				begin
					if (push && CW'(i + 1) == cnt_q)
						mem_q[i] <= '{mode1: mode_q == ASH_MODE1,
							value: shift_q[RESULT_BITS-1:0]};
					else if (i < DEPTH - 1)
						mem_q[i] <= mem_q[(i + 1) % DEPTH];
				end
				else if (push && CW'(i) == cnt_q)
					mem_q[i] <= '{mode1: mode_q == ASH_MODE1,
						value: shift_q[RESULT_BITS-1:0]};
	end

	assign sample = mem_q[0];

	////////////////////////////////////////////////////////////////////
	// checks

	logic [4:0]  fallCnt_q;
	logic [WW-1:0] sinceConv_q;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fallCnt_q   <= '0;
			sinceConv_q <= '0;
		end
		else
		begin
			fallCnt_q <= state_q == ARM ? '0 : fallCnt_q + 5'(fallNow);
			sinceConv_q <= state_q == IDLE ? '0 : sinceConv_q + WW'(1);
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_drainEntry;
		state_q == SHIFT ##1 state_q == DRAIN;
	endsequence

	sequence s_frameOpen;
		state_q == IDLE ##1 state_q == ARM;
	endsequence

	a_burst_length: assert property (s_drainEntry |->
		fallCnt_q == (pdFrame_q ? 5'd8 : 5'd16))
		else $error("wrong number of clock falls in frame");
	a_mode1_select: assert property (s_frameOpen |->
		!pins.csN throughout (##[1:400] state_q == DRAIN))
		else $error("select released inside a mode 1 frame");
	a_idle_polarity: assert property (state_q == ARM |->
		pins.sclk == (mode_q == ASH_MODE1))
		else $error("serial clock not at idle level before burst");
	a_conv_delay: assert property (state_q == CONV ##1 state_q == ARM
		|-> sinceConv_q >= WW'(CONV_WAIT_CYC))
		else $error("mode 0 read started too early");
	a_frame_phase: assert property (startNow |=> halfCnt_q == '0
		&& !phase_q)
		else $error("frame start off the clock phase");
	a_valid_after: assert property (push |=> sampleValid)
		else $error("captured word not offered");
	a_idle_select: assert property (state_q == IDLE ##1
		state_q == IDLE |-> pins.csN)
		else $error("select held between transfers");
	a_pd_sleep: assert property (s_drainEntry ##0 pdFrame_q
		##[1:3] state_q == GAP |-> asleep)
		else $error("short frame did not mark sleep");
	a_wake_time: assert property (state_q == GAP && dummy_q && halfTick
		|=> state_q == WAKE [*8])
		else $error("wake time skipped after dummy frame");
	a_hold_stall: assert property (sampleValid && !sampleReady
		|=> sampleValid && $stable(sample))
		else $error("stalled sample lost");
endmodule // ash_host

`default_nettype wire

// ### testbench/ash_adc_model.sv
/*
 behavioural converter: sends a 16-bit word msb first, counts clocks.
 assumes its pins come straight from the host; it has no clock.
*/
`timescale 1ns/100ps
`default_nettype none

module ash_adc_model (
	input  wire ash_pkg::ash_pins_t pins,
	input  wire ash_pkg::ash_mode_t mode,
	output logic                    serialOut,
	output logic [11:0]             nextWord,
	output logic                    sleeping
);
	import ash_pkg::*;

	logic [15:0] shiftQ;
	int          falls;
	logic        active;

	initial
	begin
		serialOut = 1'b0;
		nextWord = 12'h5a3;
		sleeping = 1'b0;
		active = 1'b0;
		falls = 0;
	end

	////////////////////////////////////////
	task automatic load();
		shiftQ = {4'h0, nextWord};
		nextWord = nextWord + 12'h111;
		falls = 0;
		active = 1'b1;
		serialOut = shiftQ[15];
	endtask

	// a released line shows the inverse, so a stale bit cannot pass
	task automatic drop();
		active = 1'b0;
		serialOut = ~serialOut;
	endtask

	always @(negedge pins.csN)
		if (mode == ASH_MODE1)
			load();

	always @(negedge pins.conversionStartN)
		if (mode == ASH_MODE0)
			load();

	always @(negedge pins.sclk)
		if (active)
		begin
			falls++;
			if (mode == ASH_MODE0 && falls == 16)
			begin
				#40;
				drop();
			end
		end

	always @(posedge pins.sclk)
		if (active && falls > 0 && falls < 16)
		begin
			shiftQ = shiftQ << 1;
			serialOut = shiftQ[15];
		end

	always @(posedge pins.csN)
		if (active && mode == ASH_MODE1)
		begin
			if (falls == 8)
				sleeping = 1'b1;
			else if (falls == 16)
				sleeping = 1'b0;
			drop();
		end
endmodule // ash_adc_model

`default_nettype wire

// ### testbench/test_adc_serial_read_host.sv
/*
 self-checking bench for the converter read host.
 assumes the package constants and the behavioural converter model.
*/
`timescale 1ns/100ps
`default_nettype none

module test_adc_serial_read_host;
	import ash_pkg::*;

	logic        core_clk;
	logic        resetn;
	ash_mode_t   modeSel;
	logic        runEn;
	logic [15:0] intervalSclk;
	logic        startReq;
	logic        powerDownReq;
	logic        sampleReady;
	logic        serialOut;
	logic [11:0] nextWord;
	logic        sleeping;
	ash_pins_t   pins;
	ash_sample_t sample;
	logic        sampleValid;
	logic        busy;
	logic        asleep;
	int          fails;
	int          n_tests;
	int          cyc;
	int          nFall;
	int          nCs;
	int          csAt[$];
	int          convAt;
	int          riseAt;

	ash_host ash_host_inst (
		.core_clk    (core_clk),
		.resetn      (resetn),
		.modeSel     (modeSel),
		.runEn       (runEn),
		.intervalSclk(intervalSclk),
		.startReq    (startReq),
		.powerDownReq(powerDownReq),
		.serial_out  (serialOut),
		.sampleReady (sampleReady),
		.pins        (pins),
		.sample      (sample),
		.sampleValid (sampleValid),
		.busy        (busy),
		.asleep      (asleep)
	);

	ash_adc_model ash_adc_model_inst (
		.pins     (pins),
		.mode     (modeSel),
		.serialOut(serialOut),
		.nextWord (nextWord),
		.sleeping (sleeping)
	);

	always
		#2.5 core_clk = ~core_clk;
	always @(posedge core_clk)
		cyc <= cyc + 1;
	always @(negedge pins.sclk)
		nFall++;
	always @(negedge pins.csN)
		csAt.push_back(cyc);
	always @(negedge pins.conversionStartN)
		convAt = cyc;
	always @(posedge pins.sclk)
		if (riseAt < 0)
			riseAt = cyc;

	////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic waitIdle();
		for (int n = 0; n < 5000 && busy !== 1'b0; n++)
			@(negedge core_clk);
		check("idle", 16'(busy), 16'h0);
	endtask

	task automatic frame();
		@(negedge core_clk) startReq = 1'b1;
		@(negedge core_clk) startReq = 1'b0;
		repeat (30) @(negedge core_clk);
		waitIdle();
	endtask

	task automatic getSample(output ash_sample_t s);
		for (int n = 0; n < 5000 && sampleValid !== 1'b1; n++)
			@(negedge core_clk);
		s = sample;
		check("valid", 16'(sampleValid), 16'h1);
		@(negedge core_clk);
	endtask

	task automatic setMode(input ash_mode_t m);
		@(negedge core_clk) modeSel = m;
		repeat (5) @(negedge core_clk);
	endtask

	////////////////////////////////////////
	task automatic sRead(input ash_mode_t m);
		ash_sample_t s;
		logic [11:0] w;
		setMode(m);
		w = nextWord;
		nFall = 0;
		riseAt = -1;
		nCs = csAt.size();
		@(negedge core_clk) startReq = 1'b1;
		@(negedge core_clk) startReq = 1'b0;
		getSample(s);
		waitIdle();
		check("value", 16'(s.value), 16'(w));
		check("mode flag", 16'(s.mode1), 16'(m == ASH_MODE1));
		check("falls", 16'(nFall), 16'h10);
		check("sclk idle", 16'(pins.sclk), 16'(m));
		check("cs idle", 16'(pins.csN), 16'h1);
		check("selects", 16'(csAt.size() - nCs), 16'(m));
		if (m == ASH_MODE0)
			check("conv wait", 16'(riseAt - convAt >= CONV_WAIT_CYC - 1
				&& riseAt - convAt <= CONV_WAIT_CYC + 22), 16'h1);
	endtask

	task automatic sStall();
		ash_sample_t s;
		logic [11:0] w;
		setMode(ASH_MODE1);
		w = nextWord;
		nCs = csAt.size();
		@(negedge core_clk) sampleReady = 1'b0;
		repeat (3) frame();
		repeat (400) @(negedge core_clk);
		check("full stops", 16'(csAt.size() - nCs), 16'h2);
		check("stall head", 16'(sample.value), 16'(w));
		@(negedge core_clk) sampleReady = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			getSample(s);
			check("order", 16'(s.value), 16'(w + 12'(i) * 12'h111));
		end
		waitIdle();
	endtask

	task automatic sPowerDown();
		nFall = 0;
		@(negedge core_clk) sampleReady = 1'b0;
		@(negedge core_clk) powerDownReq = 1'b1;
		@(negedge core_clk) powerDownReq = 1'b0;
		frame();
		check("pd falls", 16'(nFall), 16'h8);
		check("pd asleep", 16'(asleep), 16'h1);
		check("pd model", 16'(sleeping), 16'h1);
		nFall = 0;
		frame();
		check("dummy falls", 16'(nFall), 16'h10);
		check("awake", 16'(asleep), 16'h0);
		check("model awake", 16'(sleeping), 16'h0);
		check("dummy dropped", 16'(sampleValid), 16'h0);
		@(negedge core_clk) sampleReady = 1'b1;
	endtask

	// the timer grid is whole sclk periods, so spacing is exact
	task automatic sTimer();
		nCs = csAt.size();
		@(negedge core_clk) runEn = 1'b1;
		repeat (7000) @(negedge core_clk);
		runEn = 1'b0;
		waitIdle();
		check("timer frames", 16'(csAt.size() >= nCs + 3), 16'h1);
		if (csAt.size() >= nCs + 3)
			for (int i = 0; i < 2; i++)
				check("spacing", 16'(csAt[nCs + i + 1] - csAt[nCs + i]),
					16'(100 * 2 * SCLK_HALF_CYC));
	endtask

	////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		resetn = 1'b0;
		modeSel = ASH_MODE1;
		runEn = 1'b0;
		intervalSclk = 16'h0064;
		startReq = 1'b0;
		powerDownReq = 1'b0;
		sampleReady = 1'b1;
		cyc = 0;
		riseAt = 0;
		repeat (10) @(negedge core_clk);
		check("rst cs", 16'(pins.csN), 16'h1);
		check("rst conv", 16'(pins.conversionStartN), 16'h1);
		check("rst valid", 16'(sampleValid), 16'h0);
		@(negedge core_clk) resetn = 1'b1;
		sRead(ASH_MODE1);
		sRead(ASH_MODE0);
		sStall();
		sPowerDown();
		sRead(ASH_MODE1);
		sTimer();
		results();
	end

	initial
	begin
		#300000;
		fails++;
		results();
	end
endmodule // test_adc_serial_read_host

`default_nettype wire
